// ### common/ithp_pkg.sv
// ==========================================================
// shared constants for the interval timer host programming
package ithp_pkg;

  // ==========================================================
  // widths and counts
  localparam int ITHP_DATA_W    = 8;
  localparam int ITHP_CNT_W     = 16;
  localparam int ITHP_CHANNELS  = 3;

  // ==========================================================
  // port address decode
  localparam logic [1:0] ITHP_ADDR_CTRL = 2'h3;   // control word, write only
  localparam logic [1:0] ITHP_SEL_RB    = 2'h3;   // select code for read-back

  // ==========================================================
  // control word field positions
  localparam int ITHP_CW_SEL_HI  = 7;
  localparam int ITHP_CW_SEL_LO  = 6;
  localparam int ITHP_CW_RW_HI   = 5;
  localparam int ITHP_CW_RW_LO   = 4;
  localparam int ITHP_CW_MODE_HI = 3;
  localparam int ITHP_CW_MODE_LO = 1;
  localparam int ITHP_CW_BCD     = 0;

  // ==========================================================
  // read-back command fields, active low latch selects
  localparam int ITHP_RB_NCOUNT  = 5;
  localparam int ITHP_RB_NSTATUS = 4;
  localparam int ITHP_RB_CH0     = 1;

  // ==========================================================
  // reset values
  localparam logic [5:0]  ITHP_CW_RESET   = 6'h00;
  localparam logic [15:0] ITHP_CNTREG_RESET = 16'h0000;
  localparam logic [7:0]  ITHP_BYTE_RESET = 8'h00;
  localparam logic [4:0]  ITHP_BUS_IDLE   = 5'h1C;  // strobes and select high
  localparam logic [5:0]  ITHP_CH_IDLE    = 6'h00;

  // byte access formats
  typedef enum logic [1:0] {
    ITHP_RW_LATCH = 2'b00,
    ITHP_RW_LSB   = 2'b01,
    ITHP_RW_MSB   = 2'b10,
    ITHP_RW_BOTH  = 2'b11
  } ithp_rw_t;

  // high byte selected by the format and the byte pointer
  function automatic logic ithp_byte_hi(input logic [1:0] rw, input logic ptr);
    return (rw == ITHP_RW_MSB) || ((rw == ITHP_RW_BOTH) && ptr);
  endfunction

  // one step down, binary or four decades of bcd
  function automatic logic [15:0] ithp_dec(input logic [15:0] val, input logic bcd);
    logic [15:0] res;
    logic        borrow;
    res    = val - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      for (int i = 0; i < 4; i++) begin
        if (!borrow) begin
          res[i*4 +: 4] = val[i*4 +: 4];
        end else if (val[i*4 +: 4] == 4'h0) begin
          res[i*4 +: 4] = 4'h9;
        end else begin
          res[i*4 +: 4] = val[i*4 +: 4] - 4'h1;
          borrow        = 1'b0;
        end
      end
    end
    return res;
  endfunction

endpackage

// ### core/ithp_sync.sv
`timescale 1ns/10ps
// ==========================================================
// two flip-flop synchroniser for pins
module ithp_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ### core/ithp_down_counter.sv
`timescale 1ns/10ps
// ==========================================================
// presettable synchronous down counter, binary or bcd
module ithp_down_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  input  wire logic         bcd,
  // state
  output logic      [W-1:0] count
);
  import ithp_pkg::*;

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  // load wins over a decrement step
  assign nxt_count = load ? load_val
                   : dec  ? W'(ithp_dec(16'(count_ff), bcd))
                   : count_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

endmodule

// ### core/ithp_timer.sv
`timescale 1ns/10ps
// How it works
// - eight-bit data pins driven only during a selected counter read.
// - two address pins pick counter 0, 1, 2 or the control word.
// - read and write strobes count only while chip select is low.
// - read strobe reads a counter; write strobe writes control or count.
// - control address stores a control word and never answers reads.
// - three identical channels, each with its own mode.
// - sixteen-bit down counter, never read or written by the host directly.
// - output latch follows the counter unless latched, until read.
// - reads return a latched status byte first, else output latch bytes, one byte at a time.
// - count bytes load one at a time, move to the counter together.
// - a mode-setting control word clears both count register bytes.
// - latched status holds control word, output level and null count.
// - nothing needs a power-up value; reset gives zeros, except chip select and strobe synchronisers, which reset high.
// - top control bits pick the channel; code 11 is read-back.
// - byte access field: latch, low only, high only, low then high.
// - three mode bits pick modes 0 to 5; spare bits written zero.
// - lowest control bit picks binary or four-decade bcd counting.
// - a new count leaves the programmed mode unchanged.
module ithp_timer
  import ithp_pkg::*;
#(
  parameter int CHANNELS = ithp_pkg::ITHP_CHANNELS
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // host data pins
  input  wire logic [ithp_pkg::ITHP_DATA_W-1:0] data_in,
  output logic      [ithp_pkg::ITHP_DATA_W-1:0] data_out,
  output logic                               data_oe,
  // host address and strobes
  input  wire logic                          port_select_hi,
  input  wire logic                          port_select_lo,
  input  wire logic                          chip_select_n,
  input  wire logic                          read_n,
  input  wire logic                          write_n,
  // channel pins
  input  wire logic [CHANNELS-1:0]           count_clk,
  input  wire logic [CHANNELS-1:0]           gate,
  output logic      [CHANNELS-1:0]           timer_out
);
  import ithp_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [4:0]             bus_sync;
  logic [ITHP_DATA_W-1:0] data_sync;
  logic [2*CHANNELS-1:0]  ch_sync;

  ithp_sync #(.W(5), .RESET_VAL(ITHP_BUS_IDLE)) u_bus_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   ({chip_select_n, read_n, write_n, port_select_hi, port_select_lo}),
    .sync_out (bus_sync)
  );

  ithp_sync #(.W(ITHP_DATA_W), .RESET_VAL(ITHP_BYTE_RESET)) u_data_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   (data_in),
    .sync_out (data_sync)
  );

  ithp_sync #(.W(2*CHANNELS), .RESET_VAL((2*CHANNELS)'(ITHP_CH_IDLE))) u_ch_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   ({count_clk, gate}),
    .sync_out (ch_sync)
  );

  // ==========================================================
  // strobe qualification
  logic       s_cs_n;
  logic       s_rd_n;
  logic       s_wr_n;
  logic [1:0] s_addr;
  logic       rd_act;
  logic       wr_act;

  // address pins form the port code
  assign s_addr = bus_sync[1:0];
  assign s_cs_n = bus_sync[4];
  assign s_rd_n = bus_sync[3];
  assign s_wr_n = bus_sync[2];
  assign rd_act = ~s_cs_n & ~s_rd_n;
  assign wr_act = ~s_cs_n & ~s_wr_n;

  // ==========================================================
  // access capture; an access takes effect at its trailing edge
  logic                   rd_act_ff;
  logic                   wr_act_ff;
  logic [1:0]             rd_addr_ff;
  logic [1:0]             wr_addr_ff;
  logic [ITHP_DATA_W-1:0] wr_data_ff;
  logic [1:0]             nxt_rd_addr;
  logic [1:0]             nxt_wr_addr;
  logic [ITHP_DATA_W-1:0] nxt_wr_data;
  logic                   rd_done;
  logic                   wr_done;

  // track address and data while the strobe is low, hold them after
  assign nxt_rd_addr = rd_act ? s_addr : rd_addr_ff;
  assign nxt_wr_addr = wr_act ? s_addr : wr_addr_ff;
  assign nxt_wr_data = wr_act ? data_sync : wr_data_ff;
  assign rd_done     = rd_act_ff & ~rd_act;
  assign wr_done     = wr_act_ff & ~wr_act;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_act_ff  <= 1'b0;
      wr_act_ff  <= 1'b0;
      rd_addr_ff <= 2'h0;
      wr_addr_ff <= 2'h0;
      wr_data_ff <= ITHP_BYTE_RESET;
    end else begin
      rd_act_ff  <= rd_act;
      wr_act_ff  <= wr_act;
      rd_addr_ff <= nxt_rd_addr;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // ==========================================================
  // control word decode
  logic       cw_wr;
  logic [1:0] cw_sel;
  logic       cw_rb;
  logic [1:0] cw_rw;
  logic [2:0] cw_mode;

  assign cw_wr   = wr_done & (wr_addr_ff == ITHP_ADDR_CTRL);
  // channel select field, 11 is read-back
  assign cw_sel  = wr_data_ff[ITHP_CW_SEL_HI:ITHP_CW_SEL_LO];
  assign cw_rb   = (cw_sel == ITHP_SEL_RB);
  assign cw_rw   = wr_data_ff[ITHP_CW_RW_HI:ITHP_CW_RW_LO];
  assign cw_mode = wr_data_ff[ITHP_CW_MODE_HI:ITHP_CW_MODE_LO];

  // ==========================================================
  // channels
  logic [ITHP_DATA_W-1:0] rd_byte [CHANNELS];

  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    logic [5:0]             cw_ff;
    logic [15:0]            cnt_reg_ff;
    logic [15:0]            out_latch_ff;
    logic [7:0]             stat_ff;
    logic                   latch_held_ff;
    logic                   stat_held_ff;
    logic                   wptr_ff;
    logic                   rptr_ff;
    logic                   null_ff;
    logic                   load_pend_ff;
    logic                   armed_ff;
    logic                   out_ff;
    logic                   cclk_q_ff;
    logic [5:0]             nxt_cw;
    logic [15:0]            nxt_cnt_reg;
    logic [15:0]            nxt_out_latch;
    logic [7:0]             nxt_stat;
    logic                   nxt_latch_held;
    logic                   nxt_stat_held;
    logic                   nxt_wptr;
    logic                   nxt_rptr;
    logic                   nxt_null;
    logic                   nxt_load_pend;
    logic                   nxt_armed;
    logic                   nxt_out;
    logic [1:0]             rw;
    logic [2:0]             mode;
    logic                   prog;
    logic                   latch_cmd;
    logic                   status_cmd;
    logic                   wr_cnt;
    logic                   wr_last;
    logic                   rd_hit;
    logic                   rd_cnt;
    logic                   rd_release;
    logic                   cclk_s;
    logic                   gate_s;
    logic                   cnt_edge;
    logic                   terminal;
    logic                   ce_load;
    logic                   ce_dec;
    logic                   out_on_dec;
    logic [15:0]            ce;

    assign rw     = cw_ff[ITHP_CW_RW_HI:ITHP_CW_RW_LO];
    assign mode   = cw_ff[ITHP_CW_MODE_HI:ITHP_CW_MODE_LO];
    assign cclk_s = ch_sync[CHANNELS + i];
    assign gate_s = ch_sync[i];

    assign prog       = cw_wr & (cw_sel == 2'(i)) & (cw_rw != ITHP_RW_LATCH);
    assign latch_cmd  = cw_wr & (((cw_sel == 2'(i)) & (cw_rw == ITHP_RW_LATCH))
                      | (cw_rb & ~wr_data_ff[ITHP_RB_NCOUNT] & wr_data_ff[ITHP_RB_CH0+i]));
    assign status_cmd = cw_wr & cw_rb & ~wr_data_ff[ITHP_RB_NSTATUS]
                      & wr_data_ff[ITHP_RB_CH0+i];
    assign wr_cnt     = wr_done & (wr_addr_ff == 2'(i));
    assign wr_last    = wr_cnt & ((rw != ITHP_RW_BOTH) | wptr_ff);
    assign rd_hit     = rd_done & (rd_addr_ff == 2'(i));
    assign rd_cnt     = rd_hit & ~stat_held_ff;
    assign rd_release = rd_cnt & ((rw != ITHP_RW_BOTH) | rptr_ff);

    // mode field stored; bcd bit stored; count write keeps it
    assign nxt_cw = prog ? wr_data_ff[5:0] : cw_ff;
    // one byte per write into the count register
    assign nxt_cnt_reg = prog ? ITHP_CNTREG_RESET
                       : !wr_cnt ? cnt_reg_ff
                       : ithp_byte_hi(rw, wptr_ff) ? {wr_data_ff, cnt_reg_ff[7:0]}
                       : {cnt_reg_ff[15:8], wr_data_ff};
    // byte pointers alternate, cleared by programming
    assign nxt_wptr = prog ? 1'b0 : (wr_cnt & (rw == ITHP_RW_BOTH)) ? ~wptr_ff : wptr_ff;
    assign nxt_rptr = prog ? 1'b0 : (rd_cnt & (rw == ITHP_RW_BOTH)) ? ~rptr_ff : rptr_ff;
    // count complete: set wins over the transfer edge
    assign nxt_load_pend = prog ? 1'b0 : wr_last ? 1'b1 : cnt_edge ? 1'b0 : load_pend_ff;
    assign nxt_null      = (prog | wr_last) ? 1'b1
                         : (cnt_edge & load_pend_ff) ? 1'b0 : null_ff;
    assign nxt_armed     = prog ? 1'b0 : (cnt_edge & load_pend_ff) ? 1'b1 : armed_ff;

    // follow the counter until latched, release after the read
    assign nxt_latch_held = prog ? 1'b0 : latch_cmd ? 1'b1 : rd_release ? 1'b0 : latch_held_ff;
    assign nxt_out_latch  = latch_held_ff ? out_latch_ff : ce;
    // status snapshot of control word, output and null count
    assign nxt_stat      = (status_cmd & ~stat_held_ff) ? {out_ff, null_ff, cw_ff} : stat_ff;
    assign nxt_stat_held = status_cmd ? 1'b1 : rd_hit ? 1'b0 : stat_held_ff;

    // status first, else one output latch byte
    assign rd_byte[i] = stat_held_ff ? stat_ff
                      : ithp_byte_hi(rw, rptr_ff) ? out_latch_ff[15:8] : out_latch_ff[7:0];

    // counting on falling count clock edges, gate enabled
    assign cnt_edge = cclk_q_ff & ~cclk_s;
    assign terminal = (ce == 16'h0001) & mode[1];
    // both bytes reach the counter together
    assign ce_load  = cnt_edge & (load_pend_ff | (armed_ff & gate_s & terminal));
    assign ce_dec   = cnt_edge & ~load_pend_ff & armed_ff & gate_s & ~terminal;

    // output level per mode family on a decrement step
    assign out_on_dec = mode[1] ? (mode[0] ? out_ff : (ce != 16'h0002))
                      : mode[2] ? (ce != 16'h0001)
                      : (out_ff | (ce == 16'h0001));
    assign nxt_out = prog ? (cw_mode != 3'h0)
                   : ce_dec ? out_on_dec
                   : (ce_load & ~load_pend_ff & mode[0]) ? ~out_ff
                   : out_ff;

    // counting element hidden from the host
    ithp_down_counter #(.W(ITHP_CNT_W)) u_ce (
      .clk      (clk),
      .reset_n  (reset_n),
      .load     (ce_load),
      .load_val (cnt_reg_ff),
      .dec      (ce_dec),
      .bcd      (cw_ff[ITHP_CW_BCD]),
      .count    (ce)
    );

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cw_ff        <= ITHP_CW_RESET;
        cnt_reg_ff    <= ITHP_CNTREG_RESET;
        out_latch_ff  <= ITHP_CNTREG_RESET;
        stat_ff       <= ITHP_BYTE_RESET;
        latch_held_ff <= 1'b0;
        stat_held_ff <= 1'b0;
        wptr_ff      <= 1'b0;
        rptr_ff      <= 1'b0;
        null_ff      <= 1'b0;
        load_pend_ff <= 1'b0;
        armed_ff     <= 1'b0;
        out_ff       <= 1'b0;
        cclk_q_ff    <= 1'b0;
      end else begin
        cw_ff        <= nxt_cw;
        cnt_reg_ff    <= nxt_cnt_reg;
        out_latch_ff  <= nxt_out_latch;
        stat_ff       <= nxt_stat;
        latch_held_ff <= nxt_latch_held;
        stat_held_ff <= nxt_stat_held;
        wptr_ff      <= nxt_wptr;
        rptr_ff      <= nxt_rptr;
        null_ff      <= nxt_null;
        load_pend_ff <= nxt_load_pend;
        armed_ff     <= nxt_armed;
        out_ff       <= nxt_out;
        cclk_q_ff    <= cclk_s;
      end
    end

    assign timer_out[i] = out_ff;   // straight from the flop
  end

  // ==========================================================
  // read data path
  logic                   rd_sel;
  logic [ITHP_DATA_W-1:0] nxt_data_out;
  logic [ITHP_DATA_W-1:0] data_out_ff;
  logic                   data_oe_ff;

  // drive only during a selected counter read
  assign rd_sel       = rd_act & (s_addr != ITHP_ADDR_CTRL);
  assign nxt_data_out = rd_sel ? rd_byte[s_addr] : data_out_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out_ff <= ITHP_BYTE_RESET;
      data_oe_ff  <= 1'b0;
    end else begin
      data_out_ff <= nxt_data_out;
      data_oe_ff  <= rd_sel;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe  = data_oe_ff;

endmodule

// ### testbench/ithp_timer_properties.sv
`timescale 1ns/10ps
// ==========================================================
// port checks of the host pins
module ithp_timer_chk #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input wire logic                                 clk,
  input wire logic                                 reset_n,
  // host pins
  input wire logic [ithp_pkg::ITHP_DATA_W-1:0] data_out,
  input wire logic                                 data_oe,
  input wire logic                                 port_select_hi,
  input wire logic                                 port_select_lo,
  input wire logic                                 chip_select_n,
  input wire logic                                 read_n,
  input wire logic                                 write_n,
  // channel pins
  input wire logic [CHANNELS-1:0]                  count_clk
);
  import ithp_pkg::*;
  logic                rd_sel;
  logic                ctl_sel;
  logic                wr_only;
  logic [CHANNELS-1:0] cc_ff;
  logic [3:0]          quiet_ff;
  logic [3:0]          nxt_quiet;
  // decode of the pins as the host drives them
  assign ctl_sel = port_select_hi && port_select_lo;
  assign rd_sel = !chip_select_n && !read_n && !ctl_sel;
  assign wr_only = !write_n && read_n;
  assign nxt_quiet = (count_clk != cc_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
  // cycles for which the count clocks held still
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cc_ff    <= '0;
      quiet_ff <= 4'h0;
    end else begin
      cc_ff    <= count_clk;
      quiet_ff <= nxt_quiet;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // data pin drive
  property p_oe_rd;
    data_oe |-> !$past(read_n, 3);
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("drive without read");
  property p_oe_cs;
    data_oe |-> !$past(chip_select_n, 3);
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("drive while unselected");
  property p_oe_ctl;
    data_oe |-> !$past(ctl_sel, 3);
  endproperty
  a_oe_ctl: assert property (p_oe_ctl) else $error("control address read");
  property p_oe_rise;
    $past(rd_sel, 3) |-> data_oe;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("read not answered");
  property p_oe_wr;
    $past(wr_only, 3) |-> !data_oe;
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("drive during write");
  property p_oe_min;
    $rose(data_oe) |-> data_oe [*3];
  endproperty
  a_oe_min: assert property (p_oe_min) else $error("drive too short");
  property p_oe_lat;
    $rose(data_oe) |-> $past(rd_sel, 3) && !$past(rd_sel, 4);
  endproperty
  a_oe_lat: assert property (p_oe_lat) else $error("read answer latency");
  property p_out_hold;
    data_oe && $past(data_oe) && quiet_ff >= 4'h8 |-> $stable(data_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("read byte moved");
endmodule

bind ithp_timer ithp_timer_chk #(.CHANNELS(CHANNELS)) u_ithp_timer_chk (
  .clk(clk), .reset_n(reset_n), .data_out(data_out), .data_oe(data_oe),
  .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
  .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
  .count_clk(count_clk)
);

// ### testbench/ithp_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// host cpu behind an address decoder
module ithp_host_model (
  // clock
  input  wire logic                                clk,
  // device side of the data pins
  input  wire logic [ithp_pkg::ITHP_DATA_W-1:0] data_out,
  input  wire logic                                data_oe,
  output logic      [ithp_pkg::ITHP_DATA_W-1:0] data_in,
  // address and strobes
  output logic                                     port_select_hi,
  output logic                                     port_select_lo,
  output logic                                     chip_select_n,
  output logic                                     read_n,
  output logic                                     write_n
);
  import ithp_pkg::*;
  logic       host_oe = 1'b0;
  logic [7:0] host_byte = 8'h00;
  logic [7:0] last_ff = 8'h00;
  logic [7:0] rd_byte;  // byte taken by the last access
  logic       rd_oe;    // device drive seen by the last access
  // wire level: device, host, else a floating pattern
  assign data_in = data_oe ? data_out : host_oe ? host_byte : ~last_ff;
  always @(posedge clk) last_ff <= data_in;
  // idle pins from time zero
  initial begin
    {port_select_hi, port_select_lo} = 2'h0;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
  end
  // strobes follow system clock
  // one access: strobe low five cycles, then high six
  task automatic access(input logic cs, input logic wr, input logic [1:0] a,
                        input logic [7:0] b);
    @(negedge clk);
    {port_select_hi, port_select_lo} = a;
    chip_select_n = !cs;
    host_oe = wr;
    host_byte = b;
    write_n = !wr;
    read_n = wr;
    repeat (5) @(negedge clk);
    rd_oe = data_oe;
    rd_byte = data_in;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    host_oe = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ### testbench/tb.sv
`timescale 1ns/10ps
// ==========================================================
// self checking bench of the timer host interface
module tb;
  import ithp_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  data_in;
  logic [7:0]  data_out;
  logic        data_oe;
  logic        port_select_hi;
  logic        port_select_lo;
  logic        chip_select_n;
  logic        read_n;
  logic        write_n;
  logic [2:0]  count_clk = 3'h0;
  logic [2:0]  gate = 3'h0;
  logic [2:0]  timer_out;
  logic [31:0] seed = 32'h0745;
  int          n_fail = 0;
  int          total_checks = 0;
  // device and its host
  ithp_timer u_ithp_timer (
    .clk(clk), .reset_n(reset_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
    .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
    .count_clk(count_clk), .gate(gate), .timer_out(timer_out)
  );
  ithp_host_model u_ithp_host_model (
    .clk(clk), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
    .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n)
  );
  // clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  function automatic logic [7:0] f_stat(input logic o, input logic n, input logic [7:0] cw);
    return {o, n, cw[5:0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] b);
    u_ithp_host_model.access(1'b1, 1'b1, a, b);
  endtask
  // read a byte and compare it, drive included
  task automatic rd(input logic [1:0] a, input logic [7:0] want);
    u_ithp_host_model.access(1'b1, 1'b0, a, 8'h00);
    check({7'h00, u_ithp_host_model.rd_oe}, 8'h01);
    check(u_ithp_host_model.rd_byte, want);
  endtask
  // read that must leave the pins floating
  task automatic nord(input logic cs, input logic [1:0] a);
    u_ithp_host_model.access(cs, 1'b0, a, 8'h00);
    check({7'h00, u_ithp_host_model.rd_oe}, 8'h00);
  endtask
  // count clock taken from system clock
  task automatic cpulse(input int ch);
    @(negedge clk);
    count_clk[ch] = 1'b1;
    repeat (4) @(negedge clk);
    count_clk[ch] = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] cw;
    repeat (16) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    wr(2'h3, 8'h34);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    cpulse(0);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    // unselected write, unselected read, control address read
    u_ithp_host_model.access(1'b0, 1'b1, 2'h0, 8'hFF);
    u_ithp_host_model.access(1'b0, 1'b1, 2'h0, 8'hFF);
    cpulse(0);
    nord(1'b0, 2'h0);
    nord(1'b1, 2'h3);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    // latch, count down three, read held then live count
    gate[0] = 1'b1;
    wr(2'h3, 8'h00);
    repeat (3) cpulse(0);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    rd(2'h0, 8'h31);
    rd(2'h0, 8'h12);
    // new count keeps the mode, status shows null count
    wr(2'h0, 8'h78);
    wr(2'h0, 8'h56);
    wr(2'h3, 8'hE2);
    rd(2'h0, f_stat(1'b1, 1'b1, 8'h34));
    gate[0] = 1'b0;
    cpulse(0);
    rd(2'h0, 8'h78);
    rd(2'h0, 8'h56);
    for (int m = 0; m < 6; m++) begin
      cw = {2'b10, 2'b11, m[2:0], m[0]};
      wr(2'h3, cw);
      wr(2'h3, 8'hE8);
      rd(2'h2, f_stat(m != 0, 1'b1, cw));
    end
    // outputs: channel 0 mode 2 high, channel 1 idle low, channel 2 mode 5 high
    check({5'h00, timer_out}, 8'h05);
    // one byte formats on channels 1 and 2
    wr(2'h3, 8'h50);
    wr(2'h3, 8'hA0);
    wr(2'h1, 8'hAB);
    wr(2'h2, 8'hCD);
    cpulse(1);
    cpulse(2);
    rd(2'h1, 8'hAB);
    rd(2'h2, 8'hCD);
    rd(2'h0, 8'h78);
    rd(2'h0, 8'h56);
    wr(2'h3, 8'h70);
    rd(2'h1, 8'hAB);
    rd(2'h1, 8'h00);
    wr(2'h3, 8'hB0);
    rd(2'h2, 8'h00);
    rd(2'h2, 8'hCD);
    // four decade count: 1000 less one is 0999
    wr(2'h3, 8'h71);
    wr(2'h1, 8'h00);
    wr(2'h1, 8'h10);
    gate[1] = 1'b1;
    repeat (2) cpulse(1);
    rd(2'h1, 8'h99);
    rd(2'h1, 8'h09);
    // mode 0 outputs stay low until terminal count
    check({5'h00, timer_out}, 8'h01);
    // random counts written and read back
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(2'h3, 8'h34);
      wr(2'h0, seed[7:0]);
      wr(2'h0, seed[15:8]);
      cpulse(0);
      rd(2'h0, seed[7:0]);
      rd(2'h0, seed[15:8]);
    end
    final_report();
  end
endmodule
